// [ring_notify_defines.svh]
`ifndef RING_NOTIFY_DEFINES_SVH
`define RING_NOTIFY_DEFINES_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define RN_NUM_RINGS        4
`define RN_RING_IDX_W       2
`define RN_ADDR_W           8

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define RN_OFF_DEV_FEAT     8'h00
`define RN_OFF_DRV_FEAT     8'h04
`define RN_OFF_RING_BASE    8'h08
`define RN_OFF_RING_DEPTH   8'h0C
`define RN_OFF_RING_SEL     8'h10
`define RN_OFF_DOORBELL     8'h14
`define RN_OFF_CAUSE        8'h18
`define RN_OFF_CFG_VEC      8'h1C
`define RN_OFF_RING_VEC     8'h20
`define RN_OFF_CTRL         8'h24
`define RN_OFF_TABLE_SIZE   8'h28

// ****************************************************************
// field positions
// ****************************************************************
`define RN_FEAT_EXT_DB_BIT  28
`define RN_CTRL_MSG_EN_BIT  0
`define RN_CTRL_LEGACY_BIT  1
`define RN_DB_RING_LSB      0
`define RN_DB_OFF_LSB       16
`define RN_DB_WRAP_BIT      31

// ****************************************************************
// reset values and constants
// ****************************************************************
`define RN_DEV_FEAT_RST     32'h1000_0000
`define RN_DEPTH_MAX        16'h0100
`define RN_TABLE_SIZE       11'h007
`define RN_NO_VECTOR        16'hFFFF
`define RN_CTRL_RST         2'h0
`define RN_LEGACY_ALIGN     4096

`endif

// [ring_notify_pkg.sv]
`include "ring_notify_defines.svh"

package ring_notify_pkg;

  typedef logic [15:0]               vector_t;
  typedef logic [`RN_RING_IDX_W-1:0] ring_idx_t;

  typedef struct packed {
    logic cfg;
    logic used;
  } cause_s;

endpackage : ring_notify_pkg

// [kick_if.sv]
`timescale 1ns/1ps

interface kick_if;
  logic        valid;
  logic [15:0] ring;
  logic [14:0] next_off;
  logic        wrap;

  modport producer (output valid, output ring, output next_off, output wrap);
  modport consumer (input valid, input ring, input next_off, input wrap);
endinterface : kick_if

// [doorbell_decode.sv]
`timescale 1ns/1ps
`include "ring_notify_defines.svh"

module doorbell_decode (
  input  wire logic        strobe,
  input  wire logic [31:0] wdata,
  input  wire logic        ext_mode,
  kick_if.producer         kick
);

  // ****************************************************************
  // field split
  // ****************************************************************
  // plain mode: only the ring index matters, the upper half is dropped
  assign kick.valid    = strobe;
  assign kick.ring     = wdata[`RN_DB_RING_LSB +: 16];
  assign kick.next_off = ext_mode ? wdata[`RN_DB_OFF_LSB +: 15] : 15'h0000;
  assign kick.wrap     = ext_mode ? wdata[`RN_DB_WRAP_BIT] : 1'b0;

endmodule : doorbell_decode

// [ring_vector_map.sv]
`timescale 1ns/1ps
`include "ring_notify_defines.svh"

module ring_vector_map (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     cfg_wr,
  input  wire logic                     ring_wr,
  input  wire ring_notify_pkg::ring_idx_t ring_sel,
  input  wire logic [15:0]              wdata,
  input  wire ring_notify_pkg::ring_idx_t look_ring,
  output      ring_notify_pkg::vector_t cfg_vec,
  output      ring_notify_pkg::vector_t sel_vec,
  output      ring_notify_pkg::vector_t look_vec
);

  ring_notify_pkg::vector_t cfg_vec_q;
  ring_notify_pkg::vector_t ring_vec_q [`RN_NUM_RINGS];
  ring_notify_pkg::vector_t wr_value;

  // a mapping beyond the table fails and reads back as unmapped
  function automatic ring_notify_pkg::vector_t map_value(input logic [15:0] req);
    map_value = (req <= {5'h00, `RN_TABLE_SIZE}) ? req : `RN_NO_VECTOR;
  endfunction : map_value

  assign wr_value = map_value(wdata);

  // ****************************************************************
  // mapping storage
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_vec_q <= `RN_NO_VECTOR;
      for (int i = 0; i < `RN_NUM_RINGS; i++) begin
        ring_vec_q[i] <= `RN_NO_VECTOR;
      end
    end else begin
      if (cfg_wr) begin
        cfg_vec_q <= wr_value;
      end
      if (ring_wr) begin
        ring_vec_q[ring_sel] <= wr_value;
      end
    end
  end

  assign cfg_vec  = cfg_vec_q;
  assign sel_vec  = ring_vec_q[ring_sel];
  assign look_vec = ring_vec_q[look_ring];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_vec_readback: assert property (@(posedge clock) disable iff (reset)
    ring_wr && !cfg_wr |=> ring_vec_q[$past(ring_sel)] ==
      (($past(wdata) <= {5'h00, `RN_TABLE_SIZE}) ? $past(wdata) : `RN_NO_VECTOR))
    else $error("ring vector read-back does not match mapping result");

  chk_cfg_fail_sentinel: assert property (@(posedge clock) disable iff (reset)
    cfg_wr && wdata > {5'h00, `RN_TABLE_SIZE} |=> cfg_vec_q == `RN_NO_VECTOR)
    else $error("failed config mapping did not read as unmapped");

endmodule : ring_vector_map

// [ring_transport_irq_notify.sv]
`timescale 1ns/1ps
`include "ring_notify_defines.svh"


module ring_transport_irq_notify (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [`RN_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      logic [31:0]           reg_rdata,
  input  wire logic                  used_event,
  input  wire logic [15:0]           used_ring,
  input  wire logic                  config_event,
  output      logic                  irq_line,
  output      logic                  msg_valid,
  output      logic [15:0]           msg_vector,
  output      logic                  kick_valid,
  output      logic [15:0]           kick_ring,
  output      logic [14:0]           kick_next_off,
  output      logic                  kick_wrap
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0]                drv_feat_q;
  logic [1:0]                 ctrl_q;
  logic [15:0]                sel_q;
  logic [15:0]                depth_q [`RN_NUM_RINGS];
  logic [31:0]                base_q  [`RN_NUM_RINGS];
  ring_notify_pkg::cause_s    cause_q;
  ring_notify_pkg::cause_s    cause_d;
  ring_notify_pkg::cause_s    cause_set;
  logic                       cfg_pend_q;
  logic                       cfg_pend_d;
  logic [31:0]                rdata_q;
  logic                       irq_line_q;
  logic                       msg_valid_q;
  logic [15:0]                msg_vector_q;
  logic                       kick_valid_q;
  logic [15:0]                kick_ring_q;
  logic [14:0]                kick_next_off_q;
  logic                       kick_wrap_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic ring_exists(input logic [15:0] idx);
    ring_exists = idx < 16'(`RN_NUM_RINGS);
  endfunction : ring_exists

  logic                       msg_en;
  logic                       legacy;
  logic                       ext_db;
  logic                       sel_ok;
  logic                       used_ok;
  ring_notify_pkg::ring_idx_t sel_idx;
  ring_notify_pkg::ring_idx_t used_idx;
  logic                       wr_drv_feat;
  logic                       wr_base;
  logic                       wr_depth;
  logic                       wr_sel;
  logic                       wr_db;
  logic                       wr_cfg_vec;
  logic                       wr_ring_vec;
  logic                       wr_ctrl;
  logic                       rd_cause;
  logic                       depth_ok;
  logic [31:0]                rd_mux;

  assign msg_en      = ctrl_q[`RN_CTRL_MSG_EN_BIT];
  assign legacy      = ctrl_q[`RN_CTRL_LEGACY_BIT];
  assign ext_db      = drv_feat_q[`RN_FEAT_EXT_DB_BIT];
  assign sel_ok      = ring_exists(sel_q);
  assign used_ok     = ring_exists(used_ring);
  assign sel_idx     = sel_q[`RN_RING_IDX_W-1:0];
  assign used_idx    = used_ring[`RN_RING_IDX_W-1:0];
  assign wr_drv_feat = reg_wr && reg_addr == `RN_OFF_DRV_FEAT;
  assign wr_base     = reg_wr && reg_addr == `RN_OFF_RING_BASE && sel_ok;
  assign wr_depth    = reg_wr && reg_addr == `RN_OFF_RING_DEPTH && sel_ok;
  assign wr_sel      = reg_wr && reg_addr == `RN_OFF_RING_SEL;
  assign wr_db       = reg_wr && reg_addr == `RN_OFF_DOORBELL;
  assign wr_cfg_vec  = reg_wr && reg_addr == `RN_OFF_CFG_VEC;
  assign wr_ring_vec = reg_wr && reg_addr == `RN_OFF_RING_VEC && sel_ok;
  assign wr_ctrl     = reg_wr && reg_addr == `RN_OFF_CTRL;
  assign rd_cause    = reg_rd && reg_addr == `RN_OFF_CAUSE;

  // legacy layout has no size negotiation, so depth writes are dropped there
  assign depth_ok    = !legacy && reg_wdata[15:0] != 16'h0000 &&
                       reg_wdata[15:0] <= `RN_DEPTH_MAX;

  // ****************************************************************
  // vector mapping and doorbell
  // ****************************************************************
  ring_notify_pkg::vector_t cfg_vec;
  ring_notify_pkg::vector_t sel_vec;
  ring_notify_pkg::vector_t look_vec;

  ring_vector_map u_vec (
    .clock     (clock),
    .reset     (reset),
    .cfg_wr    (wr_cfg_vec),
    .ring_wr   (wr_ring_vec),
    .ring_sel  (sel_idx),
    .wdata     (reg_wdata[15:0]),
    .look_ring (used_idx),
    .cfg_vec   (cfg_vec),
    .sel_vec   (sel_vec),
    .look_vec  (look_vec)
  );

  kick_if kick_bus ();

  doorbell_decode u_db (
    .strobe   (wr_db),
    .wdata    (reg_wdata),
    .ext_mode (ext_db),
    .kick     (kick_bus)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  assign rd_mux =
    (reg_addr == `RN_OFF_DEV_FEAT)   ? `RN_DEV_FEAT_RST :
    (reg_addr == `RN_OFF_DRV_FEAT)   ? drv_feat_q :
    (reg_addr == `RN_OFF_RING_BASE)  ? (sel_ok ? base_q[sel_idx] : 32'h0000_0000) :
    (reg_addr == `RN_OFF_RING_DEPTH) ? {16'h0000, sel_ok ? depth_q[sel_idx] : 16'h0000} :
    (reg_addr == `RN_OFF_RING_SEL)   ? {16'h0000, sel_q} :
    (reg_addr == `RN_OFF_CAUSE)      ? {30'h0000_0000, cause_q} :
    (reg_addr == `RN_OFF_CFG_VEC)    ? {16'h0000, cfg_vec} :
    (reg_addr == `RN_OFF_RING_VEC)   ? {16'h0000, sel_ok ? sel_vec : `RN_NO_VECTOR} :
    (reg_addr == `RN_OFF_CTRL)       ? {30'h0000_0000, ctrl_q} :
    (reg_addr == `RN_OFF_TABLE_SIZE) ? {21'h00_0000, `RN_TABLE_SIZE} :
                                       32'h0000_0000;

  // ****************************************************************
  // interrupt cause and messages
  // ****************************************************************
  logic used_go;
  logic cfg_go;
  logic merge;

  // cause bits only in line mode; message mode routes through vectors
  assign cause_set.used = used_event && !msg_en;
  assign cause_set.cfg  = config_event && !msg_en;
  // set beats the clearing read
  assign cause_d        = (rd_cause ? 2'h0 : cause_q) | cause_set;

  assign used_go    = msg_en && used_event && used_ok && look_vec != `RN_NO_VECTOR;
  assign cfg_go     = msg_en && (config_event || cfg_pend_q) && cfg_vec != `RN_NO_VECTOR;
  // same vector: one message carries both causes
  assign merge      = used_go && cfg_go && cfg_vec == look_vec;
  // config message on another vector waits one cycle behind the ring message
  assign cfg_pend_d = cfg_go && used_go && !merge;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      drv_feat_q <= 32'h0000_0000;
      ctrl_q     <= `RN_CTRL_RST;
      sel_q      <= 16'h0000;
      for (int i = 0; i < `RN_NUM_RINGS; i++) begin
        depth_q[i] <= `RN_DEPTH_MAX;
        base_q[i]  <= 32'h0000_0000;
      end
    end else begin
      if (wr_drv_feat) begin
        drv_feat_q <= reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[1:0];
      end
      if (wr_sel) begin
        sel_q <= reg_wdata[15:0];
      end
      if (wr_depth && depth_ok) begin
        depth_q[sel_idx] <= reg_wdata[15:0];
      end
      if (wr_base) begin
        base_q[sel_idx] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cause_q      <= 2'h0;
      cfg_pend_q   <= 1'b0;
      irq_line_q   <= 1'b0;
      msg_valid_q  <= 1'b0;
      msg_vector_q <= 16'h0000;
      rdata_q      <= 32'h0000_0000;
    end else begin
      cause_q      <= cause_d;
      cfg_pend_q   <= cfg_pend_d;
      irq_line_q   <= (|cause_d) && !msg_en;
      msg_valid_q  <= used_go || cfg_go;
      msg_vector_q <= used_go ? look_vec : cfg_vec;
      rdata_q      <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      kick_valid_q    <= 1'b0;
      kick_ring_q     <= 16'h0000;
      kick_next_off_q <= 15'h0000;
      kick_wrap_q     <= 1'b0;
    end else begin
      kick_valid_q    <= kick_bus.valid;
      kick_ring_q     <= kick_bus.valid ? kick_bus.ring : kick_ring_q;
      kick_next_off_q <= kick_bus.valid ? kick_bus.next_off : kick_next_off_q;
      kick_wrap_q     <= kick_bus.valid ? kick_bus.wrap : kick_wrap_q;
    end
  end

  assign reg_rdata     = rdata_q;
  assign irq_line      = irq_line_q;
  assign msg_valid     = msg_valid_q;
  assign msg_vector    = msg_vector_q;
  assign kick_valid    = kick_valid_q;
  assign kick_ring     = kick_ring_q;
  assign kick_next_off = kick_next_off_q;
  assign kick_wrap     = kick_wrap_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_cause_read_clear: assert property (
    rd_cause && !used_event && !config_event |=> cause_q == 2'h0 && reg_rdata[1:0] == $past(cause_q))
    else $error("cause read did not return and clear bits");

  chk_set_wins_clear: assert property (
    rd_cause && used_event && !msg_en |=> cause_q.used && irq_line)
    else $error("used event lost against clearing read");

  chk_used_line: assert property (
    used_event && !msg_en |=> cause_q.used && irq_line ##1 (cause_q.used || $past(rd_cause)))
    else $error("line mode used event not signalled");

  chk_cfg_line: assert property (
    config_event && !msg_en |=> cause_q.cfg && irq_line)
    else $error("line mode config change not signalled");

  chk_msg_no_cause: assert property (
    msg_en && cause_q == 2'h0 && !wr_ctrl |=> cause_q == 2'h0 && !irq_line)
    else $error("cause register used in message mode");

  chk_used_msg_vec: assert property (
    used_go |=> msg_valid && msg_vector == $past(look_vec))
    else $error("used message on wrong vector");

  chk_unmapped_quiet: assert property (
    msg_en && !used_go && (cfg_vec == `RN_NO_VECTOR) |=> !msg_valid)
    else $error("message sent for unmapped event");

  chk_kick_decode: assert property (
    wr_db |=> kick_valid && kick_ring == $past(reg_wdata[15:0]))
    else $error("doorbell ring index not decoded");

  chk_kick_plain: assert property (
    wr_db && !ext_db |=> kick_next_off == 15'h0000 && !kick_wrap)
    else $error("plain doorbell carried extended fields");

  chk_depth_absent: assert property (
    reg_rd && reg_addr == `RN_OFF_RING_DEPTH && !sel_ok |=> reg_rdata == 32'h0000_0000)
    else $error("absent ring reported nonzero depth");

  chk_depth_shrink: assert property (
    wr_depth && depth_ok ##1 !wr_depth && !wr_sel ##1 reg_rd && reg_addr == `RN_OFF_RING_DEPTH
      |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
    else $error("reduced ring depth not kept");

  cov_line_both:   cover property (cause_q == 2'h3 && irq_line);
  cov_msg_merge:   cover property (merge ##1 msg_valid);
  cov_cfg_pend:    cover property (cfg_pend_q ##1 msg_valid);
  cov_kick_ext:    cover property (wr_db && ext_db && reg_wdata[`RN_DB_WRAP_BIT]);

endmodule : ring_transport_irq_notify

// [host_driver_model.sv]
`timescale 1ns/1ps
`include "ring_notify_defines.svh"

// ****************************************
// host driver on the register port
// ****************************************
module host_driver_model (
  input  wire logic        clock,
  output      logic [7:0]  reg_addr,
  output      logic [31:0] reg_wdata,
  output      logic        reg_wr,
  output      logic        reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released bus shows inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  // select first, then map, then read back to verify
  task automatic map_ring(input logic [15:0] r, input logic [15:0] v, output logic [31:0] got);
    wr(`RN_OFF_RING_SEL, {16'h0000, r});
    wr(`RN_OFF_RING_VEC, {16'h0000, v});
    rd(`RN_OFF_RING_VEC, got);
  endtask : map_ring
  // scanning per cause bit or per vector is left to the bench
endmodule : host_driver_model

// [tb_ring_transport_irq_notify.sv]
`timescale 1ns/1ps
`include "ring_notify_defines.svh"

module tb_ring_transport_irq_notify;
  logic        clock;
  logic        reset;
  logic        used_event;
  logic [15:0] used_ring;
  logic        config_event;
  wire  [7:0]  reg_addr;
  wire  [31:0] reg_wdata;
  wire         reg_wr;
  wire         reg_rd;
  logic [31:0] reg_rdata;
  logic        irq_line;
  logic        msg_valid;
  logic [15:0] msg_vector;
  logic        kick_valid;
  logic [15:0] kick_ring;
  logic [14:0] kick_next_off;
  logic        kick_wrap;
  logic [31:0] v;
  logic [15:0] mv;
  int          err_total;
  int          n_checks;

  ring_transport_irq_notify dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .used_event(used_event), .used_ring(used_ring), .config_event(config_event),
    .irq_line(irq_line), .msg_valid(msg_valid), .msg_vector(msg_vector),
    .kick_valid(kick_valid), .kick_ring(kick_ring), .kick_next_off(kick_next_off),
    .kick_wrap(kick_wrap));

  host_driver_model h (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #12.5 clock = ~clock;

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic ev(input logic u, input logic c, input logic [15:0] r);
    @(posedge clock);
    used_event   <= u;
    config_event <= c;
    used_ring    <= r;
    @(posedge clock);
    used_event   <= 1'b0;
    config_event <= 1'b0;
    used_ring    <= ~r;
    #1;
  endtask : ev

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    test_done();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    used_event = 1'b0;
    used_ring = 16'h0000;
    config_event = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    h.rd(`RN_OFF_CFG_VEC, v); check("cfg_vec_rst", 32'h0000_FFFF, v);
    h.rd(`RN_OFF_TABLE_SIZE, v); check("table_size", 32'h0000_0007, v);
    h.wr(`RN_OFF_RING_SEL, 32'h0000_0002);
    h.rd(`RN_OFF_RING_VEC, v); check("ring_vec_rst", 32'h0000_FFFF, v);
    h.map_ring(16'h0002, 16'h0005, v); check("ring_vec_ok", 32'h0000_0005, v);
    h.map_ring(16'h0001, 16'hFFFF, v); check("ring_vec_off", 32'h0000_FFFF, v);
    h.rd(`RN_OFF_RING_DEPTH, v); check("depth_rst", 32'h0000_0100, v);
    h.wr(`RN_OFF_RING_DEPTH, 32'h0000_0040);
    h.rd(`RN_OFF_RING_DEPTH, v); check("depth_small", 32'h0000_0040, v);
    h.wr(`RN_OFF_RING_SEL, 32'h0000_0004);
    h.rd(`RN_OFF_RING_DEPTH, v); check("depth_absent", 32'h0000_0000, v);
    h.wr(`RN_OFF_RING_SEL, 32'h0000_0002);
    h.rd(`RN_OFF_RING_DEPTH, v); check("depth_other", 32'h0000_0100, v);
    h.wr(`RN_OFF_CTRL, 32'h0000_0002);
    h.wr(`RN_OFF_RING_DEPTH, 32'h0000_0020);
    h.rd(`RN_OFF_RING_DEPTH, v); check("depth_legacy", 32'h0000_0100, v);
    h.wr(`RN_OFF_CTRL, 32'h0000_0000);
    h.wr(`RN_OFF_RING_BASE, 32'h0001_2345);
    h.rd(`RN_OFF_RING_BASE, v); check("ring_base", 32'h0001_2345, v);
    h.wr(`RN_OFF_CFG_VEC, 32'h0000_0003);
    h.rd(`RN_OFF_CFG_VEC, v); check("cfg_vec_ok", 32'h0000_0003, v);
    h.wr(`RN_OFF_DOORBELL, 32'h8005_0003); check("kick_v", 32'h1, 32'(kick_valid));
    check("kick_plain", 32'h0000_0003, {kick_wrap, kick_next_off, kick_ring});
    h.wr(`RN_OFF_DRV_FEAT, 32'h1000_0000);
    h.wr(`RN_OFF_DOORBELL, 32'h8005_0003); check("kick_v", 32'h1, 32'(kick_valid));
    check("kick_ext", 32'h8005_0003, {kick_wrap, kick_next_off, kick_ring});
    ev(1'b1, 1'b0, 16'h0001); check("irq_used", 32'h1, 32'(irq_line));
    h.rd(`RN_OFF_CAUSE, v); check("cause_used", 32'h0000_0001, v);
    check("irq_clear", 32'h0, 32'(irq_line));
    ev(1'b0, 1'b1, 16'h0000); check("irq_cfg", 32'h1, 32'(irq_line));
    h.rd(`RN_OFF_CAUSE, v); check("cause_cfg", 32'h0000_0002, v);
    ev(1'b1, 1'b1, 16'h0000);
    h.rd(`RN_OFF_CAUSE, v); check("cause_both", 32'h0000_0003, v);
    fork
      h.rd(`RN_OFF_CAUSE, v);
      ev(1'b1, 1'b0, 16'h0000);
    join
    check("cause_race", 32'h0000_0000, v);
    h.rd(`RN_OFF_CAUSE, v); check("cause_kept", 32'h0000_0001, v);
    h.wr(`RN_OFF_CTRL, 32'h0000_0001);
    ev(1'b1, 1'b0, 16'h0002); check("msg_used", 32'h1_0005, {15'h0, msg_valid, msg_vector});
    ev(1'b0, 1'b1, 16'h0000); check("msg_cfg", 32'h1_0003, {15'h0, msg_valid, msg_vector});
    mv = msg_vector;
    h.rd(`RN_OFF_CFG_VEC, v); check("msg_cfg_vec", v, {16'h0000, mv});
    ev(1'b1, 1'b1, 16'h0002); check("msg_both_a", 32'h1_0005, {15'h0, msg_valid, msg_vector});
    @(posedge clock);
    #1;
    check("msg_both_b", 32'h1_0003, {15'h0, msg_valid, msg_vector});
    h.map_ring(16'h0002, 16'h0003, v); check("ring_vec_merge", 32'h0000_0003, v);
    ev(1'b1, 1'b1, 16'h0002); check("msg_merge", 32'h1_0003, {15'h0, msg_valid, msg_vector});
    @(posedge clock);
    #1;
    check("msg_merge_one", 32'h0, 32'(msg_valid));
    ev(1'b1, 1'b0, 16'h0001); check("msg_unmapped", 32'h0, 32'(msg_valid));
    h.wr(`RN_OFF_CFG_VEC, 32'h0000_FFFF);
    ev(1'b0, 1'b1, 16'h0000); check("msg_cfg_off", 32'h0, 32'(msg_valid));
    h.rd(`RN_OFF_CAUSE, v); check("cause_unused", 32'h0000_0000, v);
    check("irq_msg", 32'h0, 32'(irq_line));
    test_done();
  end
endmodule : tb_ring_transport_irq_notify
